// ### ptf_pkg.sv
package ptf_pkg;

    // ============================================================
    // Widths and timing
    localparam int TOD_W = 52;
    localparam int US_CYCLES = 25;
    localparam int IVT_RES_US = 3300;
    // 24 counting bits span about 15.5 hours
    localparam logic [31:0] IVT_STEP = 32'h0000_0100;
    // Interval timer sits at decimal location 80
    localparam logic [23:0] IVT_LOC = 24'h000050;

    // ============================================================
    // Register byte offsets
    localparam logic [7:0] OFF_OP = 8'h00;
    localparam logic [7:0] OFF_DATA_HI = 8'h04;
    localparam logic [7:0] OFF_DATA_LO = 8'h08;
    localparam logic [7:0] OFF_RES_HI = 8'h0c;
    localparam logic [7:0] OFF_RES_LO = 8'h10;
    localparam logic [7:0] OFF_STORE_ADDR = 8'h14;
    localparam logic [7:0] OFF_CR0 = 8'h18;
    localparam logic [7:0] OFF_STATUS = 8'h1c;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h20;
    localparam logic [7:0] OFF_STATE = 8'h24;
    localparam logic [7:0] OFF_IVT = 8'h28;

    // ============================================================
    // Field positions and reset values
    localparam int CR0_CKC_BIT = 0;
    localparam int CR0_CPT_BIT = 1;
    localparam int ST_CKC = 0;
    localparam int ST_CPT = 1;
    localparam int ST_PRIV = 2;
    localparam int ST_TOD_BAD = 3;
    localparam int ST_W = 4;
    localparam logic [1:0] CR0_RESET = 2'h0;
    localparam logic [ST_W-1:0] MASK_RESET = 4'h0;
    localparam logic [31:0] IVT_RESET = 32'h0000_0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ============================================================
    // Operations written to the OP register
    typedef enum logic [2:0] {
        OP_NONE = 3'h0,
        OP_SET_TOD = 3'h1,
        OP_STORE_TOD = 3'h2,
        OP_SET_CKC = 3'h3,
        OP_STORE_CKC = 3'h4,
        OP_SET_CPT = 3'h5,
        OP_STORE_CPT = 3'h6
    } ptf_op_t;

    typedef enum logic [1:0] {
        MS_IDLE = 2'b00,
        MS_STORE = 2'b01,
        MS_IVT = 2'b11
    } ptf_mstate_t;

endpackage : ptf_pkg

// ### ptf_tick.sv
module ptf_tick
    import ptf_pkg::*;
#(
    parameter int DIV = US_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic en,
    output logic tick
);

    if (DIV < 2) begin : g_chk
        $error("ptf_tick: DIV must be at least 2");
    end

    localparam int CW = $clog2(DIV);
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);

    logic [CW-1:0] cnt;
    wire wrap = en && (cnt == LAST);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt <= '0;
            tick <= 1'b0;
        end else begin
            cnt <= wrap ? '0 : (en ? cnt + 1'b1 : cnt);
            tick <= wrap;
        end
    end

endmodule : ptf_tick

// ### ptf_timing.sv
// Notes on behaviour
// [R01] 52-bit time-of-day counter steps up once per microsecond and wraps.
// [R02] Clock set loads only in supervisor state with console setting enabled.
// [R03] Clock store delivers the time-of-day doubleword to the named location.
// [R04] Time-of-day keeps counting in stopped, wait and running states.
// [R05] Clock fault or microdiagnostics mark the time-of-day value invalid.
// [R06] Legacy interval word at location 80, 3.3 ms steps, 15.5 hour span.
// [R07] Interval timer frozen when stopped; updates may be skipped when busy.
// [R08] Comparator has time-of-day format and clears on initial program reset.
// [R09] Privileged set and store operations for the comparator.
// [R10] Comparator interrupt when time-of-day exceeds it, gated by both masks.
// [R11] Masked comparator request stays pending only while still exceeded.
// [R12] CPU timer in time-of-day format, top bit is the sign.
// [R13] CPU timer and time-of-day step from one common microsecond tick.
// [R14] CPU timer clears on initial program reset; privileged set and store.
// [R15] CPU timer decrements once every microsecond.
// [R16] CPU timer runs when executing or waiting, holds when stopped.
// [R17] CPU timer interrupt requested whenever its value is negative.
// [R18] Setting a positive CPU timer value clears its pending request at once.
// [R19] Privileged operations in problem state raise an exception, change nothing.
//
// Added by the designer: the AXI4-Lite slave port and the register offsets.
module ptf_timing
    import ptf_pkg::*;
#(
    parameter int IVT_US = IVT_RES_US
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic supervisor_state,
    input wire logic wait_state,
    input wire logic stopped,
    input wire logic program_state_word_ext_mask,
    input wire logic initial_program_reset,
    input wire logic tod_set_enable,
    input wire logic clock_fault,
    input wire logic clock_diag_active,
    input wire logic heavy_activity,
    output logic mem_wr_valid,
    input wire logic mem_wr_ready,
    output logic [23:0] mem_wr_addr,
    output logic [63:0] mem_wr_data,
    output logic mem_wr_dword,
    output logic ext_int_ckc,
    output logic ext_int_cpt,
    output logic priv_exception,
    output logic tod_valid,
    output logic irq
);

    if (IVT_US < 2 || IVT_US > 65535) begin : g_chk
        $error("ptf_timing: IVT_US out of range");
    end

    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // ============================================================
    // AXI4-Lite slave
    logic [TOD_W-1:0] tod;
    logic [TOD_W-1:0] ckc;
    logic [TOD_W-1:0] cpt;
    logic [19:0] data_hi;
    logic [31:0] data_lo;
    logic [63:0] res;
    logic [23:0] store_addr;
    logic [1:0] cr0;
    logic [ST_W-1:0] status;
    logic [ST_W-1:0] irq_mask;
    logic [31:0] ivt;
    logic store_req;
    logic [63:0] store_val;
    ptf_mstate_t mstate;

    wire wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !s_axi_awready;
    wire rd_go = s_axi_arvalid && !s_axi_rvalid && !s_axi_arready;
    wire wr_do = s_axi_awready;
    wire [7:0] wa = s_axi_awaddr;
    wire [31:0] wd = s_axi_wdata;
    wire wr_full = wr_do && (s_axi_wstrb != 4'h0);
    wire wr_op = wr_full && wa == OFF_OP;
    wire wr_hi = wr_full && wa == OFF_DATA_HI;
    wire wr_lo = wr_full && wa == OFF_DATA_LO;
    wire wr_sa = wr_full && wa == OFF_STORE_ADDR;
    wire wr_cr0 = wr_full && wa == OFF_CR0;
    wire wr_st = wr_full && wa == OFF_STATUS;
    wire wr_msk = wr_full && wa == OFF_IRQ_MASK;
    wire wr_ivt = wr_full && wa == OFF_IVT;
    wire wa_ok = wa[1:0] == 2'h0 && wa <= OFF_IVT;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            s_axi_awready <= wr_go;
            s_axi_wready <= wr_go;
            if (wr_do) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wa_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    wire [7:0] ra = s_axi_araddr;
    wire [31:0] state_word = {26'h0, mstate != MS_IDLE, store_req, cpt[TOD_W-1],
        tod > ckc, wait_state, tod_valid};
    wire rd_hit = ra[1:0] == 2'h0 && ra <= OFF_IVT;
    wire [31:0] rd_mux =
        ra == OFF_DATA_HI ? {12'h0, data_hi} :
        ra == OFF_DATA_LO ? data_lo :
        ra == OFF_RES_HI ? res[63:32] :
        ra == OFF_RES_LO ? res[31:0] :
        ra == OFF_STORE_ADDR ? {8'h0, store_addr} :
        ra == OFF_CR0 ? {30'h0, cr0} :
        ra == OFF_STATUS ? {28'h0, status} :
        ra == OFF_IRQ_MASK ? {28'h0, irq_mask} :
        ra == OFF_STATE ? state_word :
        ra == OFF_IVT ? ivt : 32'h0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            s_axi_arready <= rd_go;
            if (s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_mux;
                s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ============================================================
    // Operation decode
    wire [TOD_W-1:0] op_val = {data_hi, data_lo};
    wire ptf_op_t op_code = ptf_op_t'(wd[2:0]);
    wire op_priv = wr_op && op_code != OP_NONE && op_code != OP_STORE_TOD && wd[2:0] != 3'h7;
    wire op_bad = op_priv && !supervisor_state;
    wire op_ok = wr_op && !op_bad;
    wire set_tod = op_ok && op_code == OP_SET_TOD && tod_set_enable;
    wire set_ckc = op_ok && op_code == OP_SET_CKC;
    wire set_cpt = op_ok && op_code == OP_SET_CPT;
    wire st_tod = op_ok && op_code == OP_STORE_TOD;
    wire st_ckc = op_ok && op_code == OP_STORE_CKC;
    wire st_cpt = op_ok && op_code == OP_STORE_CPT;
    wire st_any = st_tod || st_ckc || st_cpt;
    wire [TOD_W-1:0] st_src = st_tod ? tod : (st_ckc ? ckc : cpt);
    wire [63:0] next_res = {st_src, 12'h000};

    // ============================================================
    // Common microsecond tick for both counters
    logic us_tick;
    logic ivt_tick;

    ptf_tick #(.DIV(US_CYCLES)) u_us (
        .aclk(aclk),
        .aresetn(aresetn),
        .en(1'b1),
        .tick(us_tick)
    );

    // Counts microseconds only while running, so a stop holds the phase too
    ptf_tick #(.DIV(IVT_US)) u_ivt (
        .aclk(aclk),
        .aresetn(aresetn),
        .en(us_tick && !stopped),
        .tick(ivt_tick)
    );

    // ============================================================
    // Counters
    wire cpt_run = us_tick && !stopped;
    wire tod_bad_ev = clock_fault || clock_diag_active;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tod <= '0;
            tod_valid <= 1'b0;
        end else begin
            if (set_tod) begin
                tod <= op_val; // [R02]
            end else if (us_tick) begin
                tod <= tod + 1'b1; // [R01] [R04] [R13]
            end
            if (tod_bad_ev) begin
                tod_valid <= 1'b0; // [R05]
            end else if (set_tod) begin
                tod_valid <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || initial_program_reset) begin
            ckc <= '0; // [R08]
            cpt <= '0; // [R14]
        end else begin
            if (set_ckc) begin
                ckc <= op_val; // [R09]
            end
            if (set_cpt) begin
                cpt <= op_val; // [R14]
            end else if (cpt_run) begin
                cpt <= cpt - 1'b1; // [R12] [R15] [R16] [R13]
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            data_hi <= '0;
            data_lo <= '0;
            res <= '0;
            store_addr <= '0;
            cr0 <= CR0_RESET;
            irq_mask <= MASK_RESET;
            priv_exception <= 1'b0;
        end else begin
            if (wr_hi) data_hi <= wd[19:0];
            if (wr_lo) data_lo <= wd;
            if (wr_sa) store_addr <= wd[23:0];
            if (wr_cr0) cr0 <= wd[1:0];
            if (wr_msk) irq_mask <= wd[ST_W-1:0];
            if (st_any) res <= next_res; // [R03] [R09] [R14]
            priv_exception <= op_bad; // [R19]
        end
    end

    // ============================================================
    // Interruption requests
    wire ckc_pend = tod > ckc; // [R10] [R11]
    wire cpt_pend = cpt[TOD_W-1]; // [R17] [R18]
    logic ckc_pend_q;
    logic cpt_pend_q;
    wire [ST_W-1:0] ev = {tod_bad_ev && tod_valid, op_bad,
        cpt_pend && !cpt_pend_q, ckc_pend && !ckc_pend_q};
    wire [ST_W-1:0] w1c = wr_st ? wd[ST_W-1:0] : '0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ckc_pend_q <= 1'b0;
            cpt_pend_q <= 1'b0;
            status <= '0;
            ext_int_ckc <= 1'b0;
            ext_int_cpt <= 1'b0;
            irq <= 1'b0;
        end else begin
            ckc_pend_q <= ckc_pend;
            cpt_pend_q <= cpt_pend;
            // A new event wins over a clear in the same cycle
            status <= (status & ~w1c) | ev;
            ext_int_ckc <= ckc_pend && program_state_word_ext_mask && cr0[CR0_CKC_BIT]; // [R10]
            ext_int_cpt <= cpt_pend && program_state_word_ext_mask && cr0[CR0_CPT_BIT]; // [R17]
            irq <= |(status & irq_mask);
        end
    end

    // ============================================================
    // Storage writes: clock stores and the interval timer word
    wire ivt_send = ivt_tick && !stopped && !heavy_activity && !store_req && !st_any; // [R07]
    logic [63:0] next_mdata;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ivt <= IVT_RESET;
        end else if (wr_ivt) begin
            ivt <= wd;
        end else if (ivt_tick && !stopped) begin
            ivt <= ivt - IVT_STEP; // [R06] [R07]
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            store_req <= 1'b0;
            store_val <= '0;
        end else if (st_any) begin
            store_req <= 1'b1;
            store_val <= next_res; // [R03]
        end else if (mstate == MS_IDLE) begin
            store_req <= 1'b0;
        end
    end

    assign next_mdata = {ivt - IVT_STEP, 32'h0};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mstate <= MS_IDLE;
            mem_wr_valid <= 1'b0;
            mem_wr_addr <= '0;
            mem_wr_data <= '0;
            mem_wr_dword <= 1'b0;
        end else begin
            unique case (mstate)
                MS_IDLE: begin
                    if (store_req) begin
                        mstate <= MS_STORE;
                        mem_wr_valid <= 1'b1;
                        mem_wr_addr <= store_addr;
                        mem_wr_data <= store_val; // [R03]
                        mem_wr_dword <= 1'b1;
                    end else if (ivt_send) begin
                        // Busy port means the update is simply skipped
                        mstate <= MS_IVT;
                        mem_wr_valid <= 1'b1;
                        mem_wr_addr <= IVT_LOC; // [R06]
                        mem_wr_data <= next_mdata;
                        mem_wr_dword <= 1'b0;
                    end
                end
                MS_STORE, MS_IVT: begin
                    if (mem_wr_ready) begin
                        mstate <= MS_IDLE;
                        mem_wr_valid <= 1'b0;
                    end
                end
            endcase
        end
    end

    // ============================================================
    // Checks
    property p_tod_step;
        us_tick && !set_tod |=> tod == $past(tod) + 1'b1;
    endproperty
    a_tod_step: assert property (p_tod_step) else $error("tod did not step"); // [R01]

    property p_tod_guard;
        wr_op && op_code == OP_SET_TOD && !(supervisor_state && tod_set_enable) && !us_tick
        |=> tod == $past(tod);
    endproperty
    a_tod_guard: assert property (p_tod_guard) else $error("tod set without permission"); // [R02]

    property p_tod_store;
        st_tod && mstate == MS_IDLE
        |=> res == {$past(tod), 12'h000} ##1 mem_wr_valid && mem_wr_data == res;
    endproperty
    a_tod_store: assert property (p_tod_store) else $error("tod store wrong"); // [R03]

    property p_tod_bad;
        tod_bad_ev |=> !tod_valid;
    endproperty
    a_tod_bad: assert property (p_tod_bad) else $error("tod still valid after fault"); // [R05]

    property p_ivt_stop;
        stopped && !wr_ivt |=> ivt == $past(ivt);
    endproperty
    a_ivt_stop: assert property (p_ivt_stop) else $error("interval timer moved"); // [R07]

    property p_ipr_clear;
        initial_program_reset |=> ckc == '0 && cpt == '0;
    endproperty
    a_ipr_clear: assert property (p_ipr_clear) else $error("reset left timers"); // [R08]

    property p_ckc_req;
        ##1 ext_int_ckc == ($past(tod > ckc) && $past(program_state_word_ext_mask)
            && $past(cr0[CR0_CKC_BIT]));
    endproperty
    a_ckc_req: assert property (p_ckc_req) else $error("comparator request wrong"); // [R10]

    property p_cpt_run;
        us_tick && !stopped && !set_cpt && !initial_program_reset |=> cpt == $past(cpt) - 1'b1;
    endproperty
    a_cpt_run: assert property (p_cpt_run) else $error("cpu timer did not step"); // [R15]

    property p_cpt_hold;
        stopped && !set_cpt && !initial_program_reset |=> $stable(cpt);
    endproperty
    a_cpt_hold: assert property (p_cpt_hold) else $error("cpu timer ran stopped"); // [R16]

    property p_cpt_pos;
        set_cpt && !op_val[TOD_W-1] && !initial_program_reset |=> ##1 !ext_int_cpt;
    endproperty
    a_cpt_pos: assert property (p_cpt_pos) else $error("cpu timer request kept"); // [R18]

    property p_priv;
        op_bad && !initial_program_reset |=> priv_exception && status[ST_PRIV]
            && $stable(ckc) && $stable(res);
    endproperty
    a_priv: assert property (p_priv) else $error("problem state op not refused"); // [R19]

    c_ckc_fire: cover property ($rose(ext_int_ckc));
    c_cpt_fire: cover property ($rose(ext_int_cpt));
    c_ivt_write: cover property (mstate == MS_IVT && mem_wr_ready);
    c_priv: cover property (priv_exception);

endmodule : ptf_timing

// ### ptf_mem_model.sv
module ptf_mem_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic mem_wr_valid,
    input wire logic [23:0] mem_wr_addr,
    input wire logic [63:0] mem_wr_data,
    input wire logic mem_wr_dword,
    input wire logic slow,
    output logic mem_wr_ready,
    output logic [23:0] dw_addr,
    output logic [63:0] dw_data,
    output logic [31:0] word,
    output int dw_cnt,
    output int word_cnt
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] hold;
    // ============================================================
    // Storage answers late when slow, to let stores queue up
    always_ff @(posedge aclk) begin
        if (!aresetn || mem_wr_ready || !mem_wr_valid) begin
            mem_wr_ready <= 1'b0;
            hold <= 2'h0;
        end else begin
            mem_wr_ready <= (hold >= (slow ? 2'h3 : 2'h0));
            hold <= hold + 2'h1;
        end
    end
    // ============================================================
    // Capture what the device leaves in storage
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dw_cnt <= 0;
            word_cnt <= 0;
        end else if (mem_wr_valid && mem_wr_ready && mem_wr_dword) begin
            dw_addr <= mem_wr_addr;
            dw_data <= mem_wr_data;
            dw_cnt <= dw_cnt + 1;
        end else if (mem_wr_valid && mem_wr_ready) begin
            word <= mem_wr_data[63:32];
            word_cnt <= word_cnt + 1;
        end
    end
endmodule : ptf_mem_model

// ### processor_timing_facilities_tb.sv
module processor_timing_facilities_tb import ptf_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 1'b0, aresetn = 1'b0, awv = 1'b0, wv = 1'b0, brdy = 1'b0, arv = 1'b0;
    logic rrdy = 1'b0, sup = 1'b1, wst = 1'b0, stp = 1'b0, emask = 1'b0, ipr = 1'b0;
    logic tse = 1'b0, fault = 1'b0, diag = 1'b0, slow = 1'b1;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, word, rd;
    logic awr, wr_rdy, bv, arr, rv, mwv, mwr, mdw, ickc, icpt, pex, tv, irq;
    logic [1:0] bresp, rresp, br, rr;
    logic [23:0] maddr, dw_addr;
    logic [63:0] mdata, dw_data;
    logic [51:0] t1, t2;
    int dw_cnt, word_cnt, n, errors = 0, samples_checked = 0, cycles = 0, pex_cnt = 0;

    initial forever #20 aclk = ~aclk;

    ptf_timing #(.IVT_US(4)) ptf_timing_inst (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr_rdy),
        .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(brdy),
        .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rrdy),
        .supervisor_state(sup), .wait_state(wst), .stopped(stp),
        .program_state_word_ext_mask(emask), .initial_program_reset(ipr),
        .tod_set_enable(tse), .clock_fault(fault), .clock_diag_active(diag),
        .heavy_activity(1'b0), .mem_wr_valid(mwv), .mem_wr_ready(mwr), .mem_wr_addr(maddr),
        .mem_wr_data(mdata), .mem_wr_dword(mdw), .ext_int_ckc(ickc), .ext_int_cpt(icpt),
        .priv_exception(pex), .tod_valid(tv), .irq(irq));

    ptf_mem_model ptf_mem_model_inst (.aclk(aclk), .aresetn(aresetn), .mem_wr_valid(mwv),
        .mem_wr_addr(maddr), .mem_wr_data(mdata), .mem_wr_dword(mdw), .slow(slow),
        .mem_wr_ready(mwr), .dw_addr(dw_addr), .dw_data(dw_data), .word(word),
        .dw_cnt(dw_cnt), .word_cnt(word_cnt));

    // ============================================================
    // Checking and run control
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic close_out();
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : close_out

    always @(posedge aclk) begin
        cycles++;
        if (pex === 1'b1) pex_cnt++;
        if (cycles == 30000) begin
            errors++;
            close_out();
        end
    end

    // ============================================================
    // Register bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        brdy <= 1'b1;
        do @(posedge aclk); while (awr !== 1'b1 || wr_rdy !== 1'b1);
        awv <= 1'b0;
        wv <= 1'b0;
        while (bv !== 1'b1) @(posedge aclk);
        br = bresp;
        brdy <= 1'b0;
    endtask : wr

    task automatic rd_reg(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arv <= 1'b1;
        rrdy <= 1'b1;
        do @(posedge aclk); while (arr !== 1'b1);
        arv <= 1'b0;
        while (rv !== 1'b1) @(posedge aclk);
        rd = rdata;
        rr = rresp;
        rrdy <= 1'b0;
    endtask : rd_reg

    task automatic set_val(input ptf_op_t op, input logic [51:0] v);
        wr(OFF_DATA_HI, {12'h000, v[51:32]});
        wr(OFF_DATA_LO, v[31:0]);
        wr(OFF_OP, {29'h0, op});
    endtask : set_val

    // Results sit left-aligned over twelve zero bits
    task automatic get_val(input ptf_op_t op, output logic [51:0] v);
        wr(OFF_OP, {29'h0, op});
        rd_reg(OFF_RES_HI);
        v[51:20] = rd;
        rd_reg(OFF_RES_LO);
        v[19:0] = rd[31:12];
    endtask : get_val

    // ============================================================
    // Scenarios
    task automatic t_regs();
        chk(tv, 1'b0);
        rd_reg(OFF_CR0);
        chk(rd[1:0], CR0_RESET);
        rd_reg(8'h3c);
        chk({rr, rd}, {RESP_SLVERR, 32'h0});
        wr(8'h3c, 32'h1);
        chk(br, RESP_SLVERR);
        wr(OFF_STORE_ADDR, 32'h200);
    endtask : t_regs

    task automatic t_tod();
        get_val(OP_STORE_TOD, t1);
        set_val(OP_SET_TOD, 52'h5_0000_0000);
        get_val(OP_STORE_TOD, t2);
        chk(t2 - t1 <= 52'd2, 1'b1);
        @(posedge aclk) tse <= 1'b1;
        set_val(OP_SET_TOD, 52'h5_0000_0000);
        n = dw_cnt;
        get_val(OP_STORE_TOD, t2);
        chk(t2 - 52'h5_0000_0000 <= 52'd2, 1'b1);
        chk(tv, 1'b1);
        while (dw_cnt == n) @(posedge aclk);
        chk(dw_addr, 24'h200);
        chk(dw_data, {t2, 12'h000});
        @(posedge aclk) stp <= 1'b1;
        get_val(OP_STORE_TOD, t1);
        repeat (250) @(posedge aclk);
        get_val(OP_STORE_TOD, t2);
        chk(t2 - t1 inside {[52'd10:52'd11]}, 1'b1);
    endtask : t_tod

    task automatic t_cpt();
        set_val(OP_SET_CPT, 52'h1000);
        repeat (300) @(posedge aclk);
        get_val(OP_STORE_CPT, t1);
        chk(t1, 52'h1000);
        @(posedge aclk) stp <= 1'b0;
        wst <= 1'b1;
        get_val(OP_STORE_CPT, t1);
        repeat (250) @(posedge aclk);
        get_val(OP_STORE_CPT, t2);
        chk(t1 - t2 inside {[52'd10:52'd11]}, 1'b1);
        @(posedge aclk) wst <= 1'b0;
        emask <= 1'b1;
        wr(OFF_CR0, 32'h3);
        set_val(OP_SET_CPT, 52'h4);
        repeat (2) @(posedge aclk);
        chk(icpt, 1'b0);
        repeat (250) @(posedge aclk);
        chk(icpt, 1'b1);
        repeat (100) @(posedge aclk);
        chk(icpt, 1'b1);
        set_val(OP_SET_CPT, 52'h4);
        repeat (2) @(posedge aclk);
        chk(icpt, 1'b0);
    endtask : t_cpt

    task automatic t_ckc();
        get_val(OP_STORE_TOD, t1);
        set_val(OP_SET_CKC, t1 + 52'd20);
        repeat (2) @(posedge aclk);
        chk(ickc, 1'b0);
        repeat (625) @(posedge aclk);
        chk(ickc, 1'b1);
        @(posedge aclk) emask <= 1'b0;
        repeat (3) @(posedge aclk);
        chk(ickc, 1'b0);
        rd_reg(OFF_STATE);
        chk(rd[2], 1'b1);
        set_val(OP_SET_CKC, 52'hf_ffff_ffff_ffff);
        rd_reg(OFF_STATE);
        chk(rd[2], 1'b0);
        get_val(OP_STORE_CKC, t1);
        chk(t1, 52'hf_ffff_ffff_ffff);
        @(posedge aclk) emask <= 1'b1;
        repeat (3) @(posedge aclk);
        chk(ickc, 1'b0);
    endtask : t_ckc

    task automatic t_ipr_priv();
        ptf_op_t ops[5] = '{OP_SET_TOD, OP_SET_CKC, OP_STORE_CKC, OP_SET_CPT, OP_STORE_CPT};
        @(posedge aclk) ipr <= 1'b1;
        @(posedge aclk) ipr <= 1'b0;
        stp <= 1'b1;
        get_val(OP_STORE_CKC, t1);
        chk(t1, 52'h0);
        get_val(OP_STORE_CPT, t1);
        chk(t1, 52'h0);
        set_val(OP_SET_CPT, 52'h2000);
        wr(OFF_IRQ_MASK, 32'h0);
        wr(OFF_STATUS, 32'hf);
        @(posedge aclk) sup <= 1'b0;
        n = pex_cnt;
        foreach (ops[i]) set_val(ops[i], 52'h777);
        @(posedge aclk) sup <= 1'b1;
        chk(pex_cnt - n, 5);
        get_val(OP_STORE_CPT, t1);
        chk(t1, 52'h2000);
        get_val(OP_STORE_CKC, t1);
        chk(t1, 52'h0);
        chk(irq, 1'b0);
        wr(OFF_IRQ_MASK, 32'h4);
        repeat (2) @(posedge aclk);
        chk(irq, 1'b1);
        wr(OFF_STATUS, 32'h4);
        repeat (2) @(posedge aclk);
        chk(irq, 1'b0);
        @(posedge aclk) stp <= 1'b0;
    endtask : t_ipr_priv

    task automatic t_ivt();
        wr(OFF_IVT, 32'h1000);
        n = word_cnt;
        repeat (1000) @(posedge aclk);
        chk(word_cnt - n inside {[9:11]}, 1'b1);
        chk(word, 32'h1000 - 32'(word_cnt - n) * 32'h100);
        @(posedge aclk) stp <= 1'b1;
        rd_reg(OFF_IVT);
        t1 = {20'h0, rd};
        n = word_cnt;
        repeat (500) @(posedge aclk);
        rd_reg(OFF_IVT);
        chk(rd, t1[31:0]);
        chk(word_cnt, n);
        @(posedge aclk) stp <= 1'b0;
        fault <= 1'b1;
        @(posedge aclk) fault <= 1'b0;
        repeat (2) @(posedge aclk);
        chk(tv, 1'b0);
        set_val(OP_SET_TOD, 52'h1);
        chk(tv, 1'b1);
        @(posedge aclk) diag <= 1'b1;
        @(posedge aclk) diag <= 1'b0;
        repeat (2) @(posedge aclk);
        chk(tv, 1'b0);
    endtask : t_ivt

    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_regs();
        t_tod();
        t_cpt();
        t_ckc();
        t_ipr_priv();
        t_ivt();
        close_out();
    end
endmodule : processor_timing_facilities_tb
